// >>> pkg/sesr_defs.svh
// Constants for the standard event status reporting block
`ifndef SESR_DEFS_SVH
`define SESR_DEFS_SVH

// ----------------------------------------------------------------
// Register reset values
// ----------------------------------------------------------------
`define SESR_FLAGS_RST   8'h80
`define SESR_MASK_RST    8'h00
`define SESR_ZERO8       8'h00

// ----------------------------------------------------------------
// Service request mask: bit 6 is never stored or reported
// ----------------------------------------------------------------
`define SESR_SRE_KEEP    8'hBF

// ----------------------------------------------------------------
// Standard event bit positions
// ----------------------------------------------------------------
`define SESR_EV_OPDONE   0
`define SESR_EV_REQCTL   1
`define SESR_EV_QUERY    2
`define SESR_EV_DEVFN    3
`define SESR_EV_EXEC     4
`define SESR_EV_CMD      5
`define SESR_EV_USER     6
`define SESR_EV_POWER    7

// ----------------------------------------------------------------
// Status byte bit positions
// ----------------------------------------------------------------
`define SESR_STB_MSGAV   4
`define SESR_STB_EVSUM   5
`define SESR_STB_SVREQ   6
// Status byte bits that may ever be set
`define SESR_STB_USED    8'h70

`endif

// >>> pkg/sesr_pkg.sv
// Types for the standard event status reporting block
`default_nettype none

package sesr_pkg;

    // ------------------------------------------------------------
    // Operation-complete tracker states, one-hot
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SESR_OPC_IDLE = 2'b01,  // No completion request pending
        SESR_OPC_WAIT = 2'b10   // Waiting for operations to finish
    } sesr_opc_e;

    // ------------------------------------------------------------
    // Whole block state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] service_request_mask;      // Service request mask
        logic [7:0] standard_event_flags;      // Standard event flags
        logic [7:0] standard_event_mask;      // Standard event mask
        sesr_opc_e  opc;      // Completion tracker
        logic [7:0] rd_data;  // Query answer
        logic       rd_valid; // Query answer strobe
        logic [7:0] stb;      // Status byte
    } sesr_state_s;

endpackage : sesr_pkg

`default_nettype wire

// >>> src/sesr_top.sv
// Standard event status registers, masks and status byte summaries
`timescale 1ns/100ps
`default_nettype none
`include "sesr_defs.svh"

module sesr_top #(
    parameter int EVW = 8  // Width of every register
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Common command strobes
    input  wire logic       cls_cmd,
    input  wire logic       sre_wr,
    input  wire logic       sre_rd,
    input  wire logic       ese_wr,
    input  wire logic       ese_rd,
    input  wire logic       esr_rd,
    input  wire logic       stb_rd,
    input  wire logic [7:0] wr_data,
    // Completion request
    input  wire logic       opc_cmd,
    input  wire logic       ops_busy,
    // Event sources
    input  wire logic       query_error,
    input  wire logic       device_function_error,
    input  wire logic       execution_error,
    input  wire logic       command_error,
    input  wire logic       user_request,
    // Output queue state
    input  wire logic       msg_avail,
    // Query answer
    output logic [7:0]      rd_data,
    output logic            rd_valid,
    // Summaries
    output logic [7:0]      status_byte,
    output logic            event_summary,
    output logic            service_request
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (EVW != 8) begin : g_bad_width
        $error("sesr_top supports only EVW = 8");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    localparam sesr_pkg::sesr_state_s RST_STATE = '{
        service_request_mask:      `SESR_MASK_RST,
        standard_event_flags:      `SESR_FLAGS_RST,
        standard_event_mask:      `SESR_MASK_RST,
        opc:      sesr_pkg::SESR_OPC_IDLE,
        rd_data:  `SESR_ZERO8,
        rd_valid: 1'b0,
        stb:      `SESR_ZERO8
    };

    sesr_pkg::sesr_state_s s;       // Registered state
    sesr_pkg::sesr_state_s next_s;  // Next state
    logic [7:0]            events;  // Events arriving this cycle
    logic                  opc_set; // Completion event this cycle

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    // Builds events, updates masks, flags, summaries and answers
    always_comb begin
        next_s   = s;
        opc_set  = 1'b0;
        // Completion tracker
        case (s.opc)
            sesr_pkg::SESR_OPC_IDLE: begin
                if (opc_cmd && !cls_cmd) begin
                    next_s.opc = sesr_pkg::SESR_OPC_WAIT;
                end
            end
            sesr_pkg::SESR_OPC_WAIT: begin
                if (cls_cmd) begin
                    // Clear abandons the pending request
                    next_s.opc = sesr_pkg::SESR_OPC_IDLE;
                end else if (!ops_busy) begin
                    opc_set    = 1'b1;
                    next_s.opc = sesr_pkg::SESR_OPC_IDLE;
                end
            end
            default: begin
                next_s.opc = sesr_pkg::SESR_OPC_IDLE;
            end
        endcase

        // Event vector in register order
        events                  = `SESR_ZERO8;
        events[`SESR_EV_OPDONE] = opc_set;
        events[`SESR_EV_REQCTL] = 1'b0;
        events[`SESR_EV_QUERY]  = query_error;
        events[`SESR_EV_DEVFN]  = device_function_error;
        events[`SESR_EV_EXEC]   = execution_error;
        events[`SESR_EV_CMD]    = command_error;
        events[`SESR_EV_USER]   = user_request;
        // Power bit is only loaded by reset
        events[`SESR_EV_POWER]  = 1'b0;

        // Flags: clear first, then new events win
        if (esr_rd || cls_cmd) begin
            next_s.standard_event_flags = `SESR_ZERO8;
        end
        next_s.standard_event_flags = next_s.standard_event_flags | events;

        // Service request mask write, bit 6 dropped
        if (sre_wr) begin
            next_s.service_request_mask = wr_data & `SESR_SRE_KEEP;
        end
        // Event mask write, weight 2^n to bit n
        if (ese_wr) begin
            next_s.standard_event_mask = wr_data;
        end

        // Status byte from the updated state
        next_s.stb = `SESR_ZERO8;
        next_s.stb[`SESR_STB_MSGAV] = msg_avail;
        next_s.stb[`SESR_STB_EVSUM] =
            |(next_s.standard_event_flags & next_s.standard_event_mask);
        next_s.stb[`SESR_STB_SVREQ] =
            |(next_s.stb & next_s.service_request_mask & `SESR_SRE_KEEP);

        // Query answer, one per cycle, flags first
        next_s.rd_valid = esr_rd | ese_rd | sre_rd | stb_rd;
        if (esr_rd) begin
            next_s.rd_data = s.standard_event_flags;
        end else if (ese_rd) begin
            next_s.rd_data = s.standard_event_mask;
        end else if (sre_rd) begin
            next_s.rd_data = s.service_request_mask & `SESR_SRE_KEEP;
        end else if (stb_rd) begin
            next_s.rd_data = s.stb;
        end else begin
            next_s.rd_data = `SESR_ZERO8;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Reset loads the power-on flag
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= RST_STATE;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rd_data         = s.rd_data;
    assign rd_valid        = s.rd_valid;
    assign status_byte     = s.stb;
    assign event_summary   = s.stb[`SESR_STB_EVSUM];
    assign service_request = s.stb[`SESR_STB_SVREQ];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // Completion request taken while idle, then tracker waiting
    sequence opc_request_s;
        opc_cmd && !cls_cmd && s.opc == sesr_pkg::SESR_OPC_IDLE;
    endsequence
    sequence opc_pending_s;
        s.opc == sesr_pkg::SESR_OPC_WAIT;
    endsequence
    // Waiting tracker finds operations idle with no clear
    sequence opc_finish_s;
        s.opc == sesr_pkg::SESR_OPC_WAIT && !ops_busy && !cls_cmd;
    endsequence

    opc_wait_enter_a: assert property (
        opc_request_s |=> opc_pending_s)
        else $error("completion request not taken");

    opc_flag_set_a: assert property (
        opc_finish_s |=> s.standard_event_flags[`SESR_EV_OPDONE] &&
            s.opc == sesr_pkg::SESR_OPC_IDLE)
        else $error("completion did not set bit 0");

    sre_write_a: assert property (
        sre_wr |=> s.service_request_mask == ($past(wr_data) & `SESR_SRE_KEEP))
        else $error("service mask write wrong");

    sre_read_a: assert property (
        sre_rd && !esr_rd && !ese_rd |=>
            rd_valid && rd_data == $past(s.service_request_mask) && !rd_data[6])
        else $error("service mask read wrong");

    esr_read_clear_a: assert property (
        esr_rd && events == `SESR_ZERO8 |=>
            rd_data == $past(s.standard_event_flags) && s.standard_event_flags == `SESR_ZERO8)
        else $error("flag read did not clear");

    event_set_wins_a: assert property (
        (esr_rd || cls_cmd) && command_error |=> s.standard_event_flags[`SESR_EV_CMD])
        else $error("event lost on clear");

    reqctl_never_a: assert property (
        !s.standard_event_flags[`SESR_EV_REQCTL])
        else $error("request control bit set");

    event_summary_a: assert property (
        event_summary == |(s.standard_event_flags & s.standard_event_mask))
        else $error("event summary mismatch");

    msg_avail_a: assert property (
        msg_avail |=> status_byte[`SESR_STB_MSGAV])
        else $error("message available not shown");

    service_req_a: assert property (
        service_request ==
            |(status_byte & s.service_request_mask & `SESR_SRE_KEEP))
        else $error("service request mismatch");

    // ------------------------------------------------------------
    // Further checks: tracker, masks, flags, answers
    // ------------------------------------------------------------
    // Completion tracker
    opc_busy_hold_a: assert property (
        s.opc == sesr_pkg::SESR_OPC_WAIT && ops_busy && !cls_cmd |=>
            s.opc == sesr_pkg::SESR_OPC_WAIT)
        else $error("completion finished while busy");

    opc_cancel_a: assert property (
        s.opc == sesr_pkg::SESR_OPC_WAIT && cls_cmd |=>
            s.opc == sesr_pkg::SESR_OPC_IDLE && !s.standard_event_flags[`SESR_EV_OPDONE])
        else $error("clear did not cancel completion");

    opc_onehot_a: assert property (
        $onehot(s.opc))
        else $error("completion tracker state not one-hot");

    // Event flags
    power_bit_quiet_a: assert property (
        !s.standard_event_flags[`SESR_EV_POWER] |=> !s.standard_event_flags[`SESR_EV_POWER])
        else $error("power-on bit set without reset");

    flag_sticky_a: assert property (
        !esr_rd && !cls_cmd |=>
            (s.standard_event_flags & $past(s.standard_event_flags)) == $past(s.standard_event_flags))
        else $error("event flag lost without read or clear");

    event_latch_a: assert property (
        events != `SESR_ZERO8 |=> (s.standard_event_flags & $past(events)) == $past(events))
        else $error("arriving event not latched");

    query_flag_a: assert property (
        query_error |=> s.standard_event_flags[`SESR_EV_QUERY])
        else $error("query error not flagged");

    user_flag_a: assert property (
        user_request |=> s.standard_event_flags[`SESR_EV_USER])
        else $error("user request not flagged");

    cls_clear_a: assert property (
        cls_cmd && events == `SESR_ZERO8 |=> s.standard_event_flags == `SESR_ZERO8)
        else $error("clear-status left flags set");

    // Masks
    sre_bit6_zero_a: assert property (
        !s.service_request_mask[`SESR_STB_SVREQ])
        else $error("service mask bit 6 stored");

    sre_zero_write_a: assert property (
        sre_wr && wr_data == `SESR_ZERO8 |=> s.service_request_mask == `SESR_ZERO8)
        else $error("service mask not cleared by zero");

    sre_hold_a: assert property (
        !sre_wr |=> $stable(s.service_request_mask))
        else $error("service mask changed without write");

    ese_write_a: assert property (
        ese_wr |=> s.standard_event_mask == $past(wr_data))
        else $error("event mask write wrong");

    ese_zero_write_a: assert property (
        ese_wr && wr_data == `SESR_ZERO8 |=> s.standard_event_mask == `SESR_ZERO8)
        else $error("event mask not cleared by zero");

    ese_hold_a: assert property (
        !ese_wr |=> $stable(s.standard_event_mask))
        else $error("event mask changed without write");

    // Query answers
    ese_read_a: assert property (
        ese_rd && !esr_rd |=>
            rd_valid && rd_data == $past(s.standard_event_mask))
        else $error("event mask read wrong");

    stb_read_a: assert property (
        stb_rd && !esr_rd && !ese_rd && !sre_rd |=>
            rd_valid && rd_data == $past(status_byte))
        else $error("status byte read wrong");

    rd_idle_a: assert property (
        !esr_rd && !ese_rd && !sre_rd && !stb_rd |=>
            !rd_valid && rd_data == `SESR_ZERO8)
        else $error("answer without query");

    // Status byte
    msg_avail_low_a: assert property (
        !msg_avail |=> !status_byte[`SESR_STB_MSGAV])
        else $error("message available shown with empty queue");

    stb_unused_a: assert property (
        (status_byte & ~`SESR_STB_USED) == `SESR_ZERO8)
        else $error("unused status bit set");

endmodule : sesr_top

`default_nettype wire

// >>> test/sesr_ops_model.sv
// Far-side model of pending instrument operations
`timescale 1ns/100ps
`default_nettype none

module sesr_ops_model #(
    parameter int LEN = 6  // Busy cycles per completion request
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Completion request and busy level
    input  wire logic opc_cmd,
    output logic      ops_busy
);
    // ------------------------------------------------------------
    // Busy counter
    // ------------------------------------------------------------
    int cnt;  // Cycles of work left

    // Work starts with the request, so completion is never instant
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
        end else if (opc_cmd) begin
            cnt <= LEN;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
        end
    end

    assign ops_busy = (cnt != 0);
endmodule : sesr_ops_model

`default_nettype wire

// >>> test/tb_standard_event_status_reporting.sv
// Self-checking bench for the status reporting block
`timescale 1ns/100ps
`default_nettype none

module tb_standard_event_status_reporting;
    // ------------------------------------------------------------
    // Stimulus and observation
    // ------------------------------------------------------------
    logic       clk = 1'b0;   // 50 MHz clock
    logic       rst_n = 1'b0; // Async reset
    logic [6:0] st = '0;      // Strobes: cls,srw,srr,esw,esr,flr,stb
    logic [4:0] ev = '0;      // Event sources, bits 2 to 6
    logic [7:0] wd = 8'h00;   // Written value
    logic       opc = 1'b0;   // Completion request
    logic       mav = 1'b0;   // Output queue not empty
    logic       busy;         // Pending operations
    logic [7:0] rdd;          // Query answer
    logic [7:0] sb;           // Status byte
    logic       rdv;          // Answer strobe
    logic       esb;          // Event summary
    logic       srq;          // Service request
    int         error_cnt = 0;
    int         comparisons = 0;
    int         b;

    always #10 clk = ~clk;

    sesr_ops_model #(.LEN(6)) ops (.clk(clk), .rst_n(rst_n),
        .opc_cmd(opc), .ops_busy(busy));

    sesr_top dut (.clk(clk), .rst_n(rst_n), .cls_cmd(st[0]),
        .sre_wr(st[1]), .sre_rd(st[2]), .ese_wr(st[3]), .ese_rd(st[4]),
        .esr_rd(st[5]), .stb_rd(st[6]), .wr_data(wd), .opc_cmd(opc),
        .ops_busy(busy), .query_error(ev[0]),
        .device_function_error(ev[1]), .execution_error(ev[2]),
        .command_error(ev[3]), .user_request(ev[4]), .msg_avail(mav),
        .rd_data(rdd), .rd_valid(rdv), .status_byte(sb),
        .event_summary(esb), .service_request(srq));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic stop_test;
        if (error_cnt == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [7:0] a, input logic [7:0] e);
        comparisons++;
        if (a !== e) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, a, e);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    // Half a cycle on, where registered outputs have settled
    task automatic look;
        @(negedge clk);
    endtask : look

    // One command strobe for one cycle
    task automatic pulse(input int i, input logic [7:0] d);
        @(posedge clk);
        st[i] <= 1'b1;
        wd <= d;
        @(posedge clk);
        st <= '0;
    endtask : pulse

    // Query and compare the answer, bounded wait
    task automatic rd(input int i, input logic [7:0] e);
        int k;
        pulse(i, 8'h00);
        for (k = 0; k < 4; k++) begin
            @(negedge clk);
            if (rdv === 1'b1) break;
        end
        if (k == 4) begin
            error_cnt++;
            stop_test();
        end
        chk(rdd, e);
    endtask : rd

    task automatic fire(input int k);
        @(posedge clk);
        ev[k] <= 1'b1;
        @(posedge clk);
        ev <= '0;
    endtask : fire

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_sre;
        pulse(1, 8'hFF);
        rd(2, 8'hBF);
        pulse(1, 8'h40);
        rd(2, 8'h00);
        pulse(1, 8'hFF);
        pulse(1, 8'h00);
        rd(2, 8'h00);
    endtask : t_sre

    // Each mask weight, and each event source against its mask bit
    task automatic t_events;
        for (b = 0; b < 8; b++) begin
            pulse(3, ~(8'h01 << b));
            if (b > 1 && b < 7) fire(b - 2);
            cyc(2);
            look();
            chk({7'h00, esb}, 8'h00);
            pulse(3, 8'h01 << b);
            rd(4, 8'h01 << b);
            if (b > 1 && b < 7) begin
                chk({7'h00, esb}, 8'h01);
                chk(sb, 8'h20);
                rd(5, 8'h01 << b);
                cyc(2);
                look();
                chk({7'h00, esb}, 8'h00);
            end
        end
    endtask : t_events

    task automatic t_srq;
        pulse(3, 8'hFF);
        pulse(1, 8'h20);
        fire(3);
        cyc(2);
        look();
        chk({7'h00, srq}, 8'h01);
        rd(6, 8'h60);
        @(posedge clk);
        mav <= 1'b1;
        pulse(1, 8'h10);
        rd(6, 8'h70);
        pulse(1, 8'h8F);
        rd(6, 8'h30);
        @(posedge clk);
        mav <= 1'b0;
        rd(5, 8'h20);
        rd(6, 8'h00);
    endtask : t_srq

    task automatic t_opc;
        @(posedge clk);
        opc <= 1'b1;
        @(posedge clk);
        opc <= 1'b0;
        rd(5, 8'h00);
        cyc(10);
        rd(5, 8'h01);
        // Clear-status while the request still waits abandons it
        @(posedge clk);
        opc <= 1'b1;
        @(posedge clk);
        opc <= 1'b0;
        pulse(0, 8'h00);
        cyc(10);
        rd(5, 8'h00);
    endtask : t_opc

    // Event in the cycle of a destructive read, then clear-status
    task automatic t_race_cls;
        @(posedge clk);
        st[5] <= 1'b1;
        ev[2] <= 1'b1;
        @(posedge clk);
        st <= '0;
        ev <= '0;
        look();
        chk({7'h00, rdv}, 8'h01);
        chk(rdd, 8'h00);
        rd(5, 8'h10);
        fire(1);
        pulse(0, 8'h00);
        rd(5, 8'h00);
        rd(4, 8'hFF);
    endtask : t_race_cls

    // Power cycle in mid-run: flags reload, masks return to zero
    task automatic t_power;
        fire(0);
        pulse(1, 8'hFF);
        @(posedge clk);
        rst_n <= 1'b0;
        cyc(2);
        rst_n <= 1'b1;
        rd(5, 8'h80);
        rd(2, 8'h00);
        rd(4, 8'h00);
        rd(6, 8'h00);
    endtask : t_power

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        cyc(3);
        rst_n <= 1'b1;
        rd(5, 8'h80);
        rd(5, 8'h00);
        t_sre();
        t_events();
        t_srq();
        t_opc();
        t_race_cls();
        t_power();
        stop_test();
    end

    initial begin
        cyc(5000);
        error_cnt++;
        stop_test();
    end
endmodule : tb_standard_event_status_reporting

`default_nettype wire
